/* logic/epi_pkg.sv */
// Shared constants for the external pin interrupt block
package epi_pkg;
   // Register byte offsets on the APB
   localparam logic [7:0] EPI_OFF_SENSE   = 8'h00; // sense_control
   localparam logic [7:0] EPI_OFF_CRS     = 8'h04; // control_and_reset_status
   localparam logic [7:0] EPI_OFF_ENABLE  = 8'h08; // pin_irq_enable
   localparam logic [7:0] EPI_OFF_PENDING = 8'h0C; // pin_irq_pending
   localparam logic [7:0] EPI_OFF_STATUS  = 8'h10; // sticky event status
   localparam logic [7:0] EPI_OFF_MASK    = 8'h14; // event mask
   localparam logic [7:0] EPI_OFF_STATE   = 8'h18; // live state, read only

   // Field positions
   localparam int EPI_SENSE_A_LO = 0;  // sense_a_lo
   localparam int EPI_SENSE_A_HI = 1;  // sense_a_hi
   localparam int EPI_SENSE_B_LO = 2;  // sense_b_lo
   localparam int EPI_SENSE_B_HI = 3;  // sense_b_hi
   localparam int EPI_SENSE_EDGE_C = 6; // sense_edge_c
   localparam int EPI_BIT_B = 7;       // enable and pending of pin b
   localparam int EPI_BIT_A = 6;       // enable and pending of pin a
   localparam int EPI_BIT_C = 5;       // enable and pending of pin c

   // Event status and mask bits
   localparam int EPI_EV_A    = 0;
   localparam int EPI_EV_B    = 1;
   localparam int EPI_EV_C    = 2;
   localparam int EPI_EV_WAKE = 3;

   // Writable bit masks and reset values
   localparam logic [7:0] EPI_SENSE_WMASK  = 8'h0F;
   localparam logic [7:0] EPI_CRS_WMASK    = 8'h40;
   localparam logic [7:0] EPI_ENABLE_WMASK = 8'hE0;
   localparam logic [3:0] EPI_EV_WMASK     = 4'hF;
   localparam logic [7:0] EPI_RST_BYTE     = 8'h00;
   localparam logic [3:0] EPI_RST_EV       = 4'h0;

   // Sense mode encoding of the two-bit fields
   localparam logic [1:0] EPI_MODE_LOW    = 2'h0;
   localparam logic [1:0] EPI_MODE_CHANGE = 2'h1;
   localparam logic [1:0] EPI_MODE_FALL   = 2'h2;
   localparam logic [1:0] EPI_MODE_RISE   = 2'h3;

   // Consecutive watchdog samples needed before a level wake
   localparam int EPI_WAKE_SAMPLES = 2;

   // Wake sequencer states
   typedef enum logic [1:0] {
      EPI_AWAKE,
      EPI_ASLEEP,
      EPI_STARTUP
   } epi_wake_t;
endpackage : epi_pkg

/* logic/epi_top.sv */
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
module epi_top
   import epi_pkg::*;
#(
   parameter int WAKE_SAMPLES = EPI_WAKE_SAMPLES  // consecutive low samples for wake
)(
   input  wire logic        clk,            // 20 MHz block clock
   input  wire logic        rst,            // asynchronous, active high
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins and port state
   input  wire logic [2:0]  pin_pad,        // pad levels: bit0 a, bit1 b, bit2 c
   input  wire logic [2:0]  port_out,       // port data register bits
   input  wire logic [2:0]  port_dir,       // 1: pin driven as output
   // CPU side
   input  wire logic        cpu_global_ie,  // I-bit of cpu_status_word
   input  wire logic [2:0]  irq_ack,        // routine entered: bit0 a, bit1 b, bit2 c
   output logic             irq_req_a,      // request to vector of pin a
   output logic             irq_req_b,      // request to vector of pin b
   output logic             irq_req_c,      // request to vector of pin c
   // Power management side
   input  wire logic        io_clk_run,     // I/O clock running
   input  wire logic        sleep_deep,     // deep sleep entered
   input  wire logic        wdt_tick,       // watchdog oscillator sample pulse
   input  wire logic        startup_done,   // start-up time over
   output logic             wake_req,       // wake the part
   output logic             irq             // unmasked event interrupt
);

   // Refuse a wake count the counter cannot hold
   if (WAKE_SAMPLES < 1 || WAKE_SAMPLES > 15) begin : g_chk
      $error("WAKE_SAMPLES must be 1 to 15");
   end

   // Registers
   logic [7:0] sense_control;               // sense bits of a and b
   logic [7:0] control_and_reset_status;    // only the c edge select lives here
   logic [7:0] pin_irq_enable;              // per pin enables
   logic [7:0] pin_irq_pending;             // per pin pending flags
   logic [3:0] ev_status;                   // sticky events
   logic [3:0] ev_mask;                     // event mask

   // Pin sampling
   logic [2:0] pad_s1;                      // first synchroniser stage
   logic [2:0] pad_s2;                      // second synchroniser stage
   logic [2:0] pin_now;                     // sampled pin value
   logic [2:0] pin_prev;                    // previous sample
   logic       run_s1;                      // I/O clock flag stage one
   logic       run_s2;                      // I/O clock flag stage two

   // Wake sequencer
   epi_wake_t  wake_state;                  // current wake state
   logic [3:0] low_count;                   // consecutive low samples

   // Bus decode
   logic       acc;                         // access phase completes
   logic       wr;                          // completing write
   logic [3:0] wr_bits;                     // low four bits of write data

   // Detection
   logic [1:0] mode_a;                      // decoded sense of a
   logic [1:0] mode_b;                      // decoded sense of b
   logic       hit_a;                       // edge event on a
   logic       hit_b;                       // edge event on b
   logic       hit_c;                       // edge event on c
   logic       vis_c;                       // c level oriented by edge select
   logic       vis_c_prev;                  // previous oriented level
   logic       lvl_a;                       // low-level request of a
   logic       lvl_b;                       // low-level request of b
   logic       lvl_low_any;                 // any enabled level source low
   logic [7:0] clr_pend;                    // pending clear requests
   logic [7:0] set_pend;                    // pending set requests
   logic       wake_ev;                     // wake granted this cycle

   // Edge test on one sample pair by sense mode
   function automatic logic epi_edge(input logic [1:0] mode,
                                     input logic       now,
                                     input logic       prev);
      logic res;
      res = 1'b0;
      case (mode)
         EPI_MODE_CHANGE: res = now ^ prev;      // any change
         EPI_MODE_FALL:   res = prev & ~now;     // falling edge
         EPI_MODE_RISE:   res = now & ~prev;     // rising edge
         default:         res = 1'b0;            // low level: no edge
      endcase
      return res;
   endfunction : epi_edge

   // Register read mux
   function automatic logic [31:0] epi_read(input logic [7:0] addr,
                                            input logic [7:0] sc,
                                            input logic [7:0] crs,
                                            input logic [7:0] en,
                                            input logic [7:0] pend,
                                            input logic [3:0] st,
                                            input logic [3:0] mk,
                                            input logic [7:0] live);
      logic [31:0] d;
      d = 32'h00000000;
      case (addr)
         EPI_OFF_SENSE:   d = {24'h000000, sc};
         EPI_OFF_CRS:     d = {24'h000000, crs};
         EPI_OFF_ENABLE:  d = {24'h000000, en};
         EPI_OFF_PENDING: d = {24'h000000, pend};
         EPI_OFF_STATUS:  d = {28'h0000000, st};
         EPI_OFF_MASK:    d = {28'h0000000, mk};
         EPI_OFF_STATE:   d = {24'h000000, live};
         default:         d = 32'h00000000;
      endcase
      return d;
   endfunction : epi_read

   // Known offsets
   function automatic logic epi_mapped(input logic [7:0] addr);
      return (addr == EPI_OFF_SENSE)   || (addr == EPI_OFF_CRS)    ||
             (addr == EPI_OFF_ENABLE)  || (addr == EPI_OFF_PENDING) ||
             (addr == EPI_OFF_STATUS)  || (addr == EPI_OFF_MASK)    ||
             (addr == EPI_OFF_STATE);
   endfunction : epi_mapped

   // Bus strobes
   assign acc     = psel & penable & pready;
   assign wr      = acc & pwrite & epi_mapped(paddr);
   assign wr_bits = pwdata[3:0];

   // APB answer: one wait state, ready and data registered
   // Unmapped offsets: pslverr, no write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel & penable & ~pready) begin
         // Answer next edge
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h00000000 :
                    epi_read(paddr, sense_control, control_and_reset_status,
                             pin_irq_enable, pin_irq_pending, ev_status, ev_mask,
                             {pin_now, 1'b0, low_count});
         pslverr <= ~epi_mapped(paddr);
      end else begin
         // Drop after the completing edge
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

   // Two-stage synchronisers for pads and the I/O clock flag
   // Reset high: idle pads give no edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_s1 <= 3'h7;
         pad_s2 <= 3'h7;
         run_s1 <= 1'b0;
         run_s2 <= 1'b0;
      end else begin
         pad_s1 <= pin_pad;
         pad_s2 <= pad_s1;
         run_s1 <= io_clk_run;
         run_s2 <= run_s1;
      end
   end

   // Sample the pin; an output pin is seen through its port bit
   // Software can trigger via the port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_now  <= 3'h7;
         pin_prev <= 3'h7;
      end else begin
         pin_now  <= (port_dir & port_out) | (~port_dir & pad_s2);
         pin_prev <= pin_now;
      end
   end

   // Sense decode of a and b
   assign mode_a = {sense_control[EPI_SENSE_A_HI], sense_control[EPI_SENSE_A_LO]};
   assign mode_b = {sense_control[EPI_SENSE_B_HI], sense_control[EPI_SENSE_B_LO]};

   // Edges of a and b only while the I/O clock runs
   // Edges while halted are lost
   assign hit_a = run_s2 & epi_edge(mode_a, pin_now[0], pin_prev[0]);
   assign hit_b = run_s2 & epi_edge(mode_b, pin_now[1], pin_prev[1]);

   // Pin c: edge only, direction from the select bit, works in sleep
   // No clock gate: c can wake the part
   assign vis_c = control_and_reset_status[EPI_SENSE_EDGE_C] ? pin_now[2] : ~pin_now[2];
   assign hit_c = vis_c & ~vis_c_prev;

   // Oriented c level history; a select change may look like an edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vis_c_prev <= 1'b1;
      end else begin
         vis_c_prev <= vis_c;
      end
   end

   // Low-level requests, held back until the part is fully awake
   assign lvl_a = (mode_a == EPI_MODE_LOW) & ~pin_now[0] & pin_irq_enable[EPI_BIT_A];
   assign lvl_b = (mode_b == EPI_MODE_LOW) & ~pin_now[1] & pin_irq_enable[EPI_BIT_B];
   assign lvl_low_any = lvl_a | lvl_b;

   // Pending flag set and clear terms
   always_comb begin
      set_pend = 8'h00;
      clr_pend = 8'h00;
      set_pend[EPI_BIT_A] = hit_a;
      set_pend[EPI_BIT_B] = hit_b;
      set_pend[EPI_BIT_C] = hit_c;
      if (wr && paddr == EPI_OFF_PENDING) begin
         clr_pend = pwdata[7:0] & EPI_ENABLE_WMASK;
      end
      clr_pend[EPI_BIT_A] = clr_pend[EPI_BIT_A] | irq_ack[0];
      clr_pend[EPI_BIT_B] = clr_pend[EPI_BIT_B] | irq_ack[1];
      clr_pend[EPI_BIT_C] = clr_pend[EPI_BIT_C] | irq_ack[2];
   end

   // Pending flags: set beats clear, level mode forces zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_irq_pending <= EPI_RST_BYTE;
      end else begin
         pin_irq_pending <= set_pend | (pin_irq_pending & ~clr_pend);
         if (mode_a == EPI_MODE_LOW) begin
            pin_irq_pending[EPI_BIT_A] <= 1'b0;
         end
         if (mode_b == EPI_MODE_LOW) begin
            pin_irq_pending[EPI_BIT_B] <= 1'b0;
         end
         pin_irq_pending[4:0] <= 5'h00;
      end
   end

   // Configuration registers written over the bus
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sense_control            <= EPI_RST_BYTE;
         control_and_reset_status <= EPI_RST_BYTE;
         pin_irq_enable           <= EPI_RST_BYTE;
         ev_mask                  <= EPI_RST_EV;
      end else if (wr) begin
         case (paddr)
            EPI_OFF_SENSE:  sense_control <= pwdata[7:0] & EPI_SENSE_WMASK;
            EPI_OFF_CRS:    control_and_reset_status <= pwdata[7:0] & EPI_CRS_WMASK;
            EPI_OFF_ENABLE: pin_irq_enable <= pwdata[7:0] & EPI_ENABLE_WMASK;
            EPI_OFF_MASK:   ev_mask <= wr_bits & EPI_EV_WMASK;
            default:        ev_mask <= ev_mask; // Other offsets leave these alone
         endcase
      end
   end

   // Wake sequencer: level sampling by watchdog ticks, then start-up
   // With WAKE_SAMPLES of 2 or more, one noisy low sample cannot wake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_state <= EPI_AWAKE;
         low_count  <= 4'h0;
         wake_req   <= 1'b0;
      end else begin
         case (wake_state)
            EPI_AWAKE: begin
               // Wait for deep sleep
               low_count <= 4'h0;
               wake_req  <= 1'b0;
               if (sleep_deep) begin
                  wake_state <= EPI_ASLEEP;
               end
            end
            EPI_ASLEEP: begin
               if (hit_c && pin_irq_enable[EPI_BIT_C]) begin
                  // Async c edge wakes at once
                  wake_state <= EPI_STARTUP;
                  wake_req   <= 1'b1;
                  low_count  <= 4'h0;
               end else if (wdt_tick) begin
                  if (!lvl_low_any) begin
                     low_count <= 4'h0; // Streak broken
                  end else if (low_count == 4'(WAKE_SAMPLES - 1)) begin
                     wake_state <= EPI_STARTUP;
                     wake_req   <= 1'b1;
                     low_count  <= 4'h0;
                  end else begin
                     low_count <= low_count + 4'h1;
                  end
               end
            end
            EPI_STARTUP: begin
               // Hold wake until start-up ends
               if (startup_done) begin
                  wake_state <= EPI_AWAKE;
                  wake_req   <= 1'b0;
               end
            end
            default: begin
               wake_state <= EPI_AWAKE;
               wake_req   <= 1'b0;
               low_count  <= 4'h0;
            end
         endcase
      end
   end

   // Wake granted this cycle, for the event status
   assign wake_ev = (wake_state == EPI_ASLEEP) &
                    ((hit_c & pin_irq_enable[EPI_BIT_C]) |
                     (wdt_tick & lvl_low_any & (low_count == 4'(WAKE_SAMPLES - 1))));

   // Per-vector requests; level needs the part awake and pin still low
   // Level gone at wake: no request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_req_a <= 1'b0;
         irq_req_b <= 1'b0;
         irq_req_c <= 1'b0;
      end else begin
         irq_req_a <= cpu_global_ie & pin_irq_enable[EPI_BIT_A] &
                      (pin_irq_pending[EPI_BIT_A] | (lvl_a & wake_state == EPI_AWAKE));
         irq_req_b <= cpu_global_ie & pin_irq_enable[EPI_BIT_B] &
                      (pin_irq_pending[EPI_BIT_B] | (lvl_b & wake_state == EPI_AWAKE));
         irq_req_c <= cpu_global_ie & pin_irq_enable[EPI_BIT_C] &
                      pin_irq_pending[EPI_BIT_C];
      end
   end

   // Sticky event status, write one to clear, set wins
   // Logged even with request disabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ev_status <= EPI_RST_EV;
      end else begin
         ev_status <= {wake_ev, hit_c, hit_b, hit_a} |
                      (ev_status & ~((wr && paddr == EPI_OFF_STATUS) ? wr_bits : 4'h0));
      end
   end

   // Single interrupt line from unmasked events
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ev_status & ev_mask);
      end
   end

endmodule : epi_top

/* dv/epi_top_props.sv */
`timescale 1ns/1ns
// Port checker for the pin interrupt block
module epi_top_props
   import epi_pkg::*;
#(
   parameter int WAKE_SAMPLES = EPI_WAKE_SAMPLES // Level wake samples
)(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [2:0]  pin_pad,
   input wire logic [2:0]  port_out,
   input wire logic [2:0]  port_dir,
   input wire logic        cpu_global_ie,
   input wire logic        irq_req_a,
   input wire logic        irq_req_b,
   input wire logic        irq_req_c,
   input wire logic        sleep_deep,
   input wire logic        wdt_tick,
   input wire logic        startup_done,
   input wire logic        wake_req
);
   logic       wr_done;  // Completed write
   logic       pin_a;    // Level seen on pin a
   logic [7:0] sense_sh; // Shadow of sense_control
   logic [7:0] en_sh;    // Shadow of pin_irq_enable
   assign wr_done = psel && penable && pready && pwrite;
   assign pin_a   = port_dir[0] ? port_out[0] : pin_pad[0];
   // Track sense_control writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sense_sh <= 8'h00;
      end else if (wr_done && paddr == EPI_OFF_SENSE) begin
         sense_sh <= pwdata[7:0];
      end
   end
   // Track pin_irq_enable writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_sh <= 8'h00;
      end else if (wr_done && paddr == EPI_OFF_ENABLE) begin
         en_sh <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_ready_wait: assert property ($rose(penable) && psel |=> pready)
      else $error("pready not one cycle after access");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_err_decode: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h18))
      else $error("pslverr wrong for offset");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
   a_pend_zero: assert property (pready && !pwrite && paddr == EPI_OFF_PENDING
      |-> prdata[31:8] == 24'h0 && prdata[4:0] == 5'h0) else $error("reserved pending bits");
   a_req_gate: assert property (irq_req_a || irq_req_b || irq_req_c
      |-> $past(cpu_global_ie)) else $error("request without global enable");
   a_req_enable: assert property (irq_req_b |-> $past(en_sh[EPI_BIT_B]))
      else $error("request b without enable");
   a_level_hold: assert property ((sense_sh[1:0] == EPI_MODE_LOW && en_sh[EPI_BIT_A]
      && cpu_global_ie && !pin_a && !sleep_deep && !wake_req) [*6] |-> irq_req_a)
      else $error("low level not requesting");
   a_wake_tick: assert property ($rose(wake_req) && !en_sh[EPI_BIT_C]
      |-> $past(wdt_tick) || $past(wdt_tick, 2)) else $error("level wake without sample");
   a_wake_end: assert property ($fell(wake_req) |-> $past(startup_done)
      || $past(startup_done, 2)) else $error("wake dropped before start-up");
   c_slverr: cover property (pready && pslverr);
   c_wake: cover property ($rose(wake_req));
   c_req_c: cover property (irq_req_c);
endmodule : epi_top_props
bind epi_top epi_top_props #(.WAKE_SAMPLES(WAKE_SAMPLES)) u_props (.clk(clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_pad(pin_pad),
   .port_out(port_out), .port_dir(port_dir), .cpu_global_ie(cpu_global_ie),
   .irq_req_a(irq_req_a), .irq_req_b(irq_req_b), .irq_req_c(irq_req_c),
   .sleep_deep(sleep_deep), .wdt_tick(wdt_tick), .startup_done(startup_done),
   .wake_req(wake_req));

/* dv/epi_pin_model.sv */
`timescale 1ns/1ns
// Pads and CPU entry logic beside the block
module epi_pin_model (
   input  wire logic       clk,
   input  wire logic       irq_req_a,
   input  wire logic       irq_req_b,
   input  wire logic       irq_req_c,
   output logic      [2:0] pin_pad,
   output logic      [2:0] irq_ack
);
   logic       auto_ack; // CPU takes requests
   int         ack_wait; // Latency of routine entry
   logic [2:0] req;      // Requests by pin
   assign req = {irq_req_c, irq_req_b, irq_req_a};
   // Pads idle high through pull-ups
   initial begin
      pin_pad  = 3'h7;
      irq_ack  = 3'h0;
      auto_ack = 1'b0;
      ack_wait = 3;
   end
   // Move one pad just after an edge
   task automatic set_pin(input int i, input logic v);
      @(posedge clk);
      pin_pad[i] <= v;
   endtask : set_pin
   // Enter one routine, lowest pin first, then let the flag clear
   always begin
      @(posedge clk);
      if (auto_ack && req != 3'h0) begin
         repeat (ack_wait) @(posedge clk);
         irq_ack <= req & (~req + 3'h1);
         @(posedge clk);
         irq_ack <= 3'h0;
         repeat (3) @(posedge clk);
      end
   end
endmodule : epi_pin_model

/* dv/testbench.sv */
`timescale 1ns/1ns
// Register and pin sequences for the pin interrupt block
module testbench;
   import epi_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic        pready, pslverr, rerr, irq_req_a, irq_req_b, irq_req_c, wake_req, irq;
   logic [2:0]  pin_pad, irq_ack, port_out = 3'h0, port_dir = 3'h0;
   logic        cpu_global_ie = 1'b0, io_clk_run = 1'b1, sleep_deep = 1'b0;
   logic        wdt_tick = 1'b0, startup_done = 1'b0;
   int          error_cnt = 0, checked = 0;
   always #25 clk = ~clk;
   epi_top #(.WAKE_SAMPLES(2)) uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_pad(pin_pad), .port_out(port_out), .port_dir(port_dir),
      .cpu_global_ie(cpu_global_ie), .irq_ack(irq_ack), .irq_req_a(irq_req_a),
      .irq_req_b(irq_req_b), .irq_req_c(irq_req_c), .io_clk_run(io_clk_run),
      .sleep_deep(sleep_deep), .wdt_tick(wdt_tick), .startup_done(startup_done),
      .wake_req(wake_req), .irq(irq));
   epi_pin_model pm (.clk(clk), .irq_req_a(irq_req_a), .irq_req_b(irq_req_b),
      .irq_req_c(irq_req_c), .pin_pad(pin_pad), .irq_ack(irq_ack));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      chk({31'h0, rerr}, {31'h0, a > EPI_OFF_STATE});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask : rd
   // Room for sync, detect and flag
   task automatic settle();
      repeat (8) @(posedge clk);
   endtask : settle
   // One watchdog sample
   task automatic tick();
      @(posedge clk);
      wdt_tick <= 1'b1;
      @(posedge clk);
      wdt_tick <= 1'b0;
   endtask : tick
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   // Hang guard
   initial begin
      #300000;
      error_cnt++;
      close_out();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int o = 0; o <= 8'h1C; o += 4) rd(o[7:0], (o == 8'h18) ? 32'hE0 : 32'h0);
      wr(8'h1C, 32'hFF);
      wr(EPI_OFF_SENSE, 32'hFF);
      rd(EPI_OFF_SENSE, 32'h0F);
      wr(EPI_OFF_CRS, 32'hFF);
      rd(EPI_OFF_CRS, 32'h40);
      wr(EPI_OFF_ENABLE, 32'hFF);
      rd(EPI_OFF_ENABLE, 32'hE0);
      cpu_global_ie <= 1'b1;
      // Every edge mode on pins a and b, both directions
      for (int p = 0; p < 2; p++) begin
         for (int m = 1; m < 4; m++) begin
            wr(EPI_OFF_SENSE, m << (2 * p));
            wr(EPI_OFF_PENDING, 32'hE0);
            pm.set_pin(p, 1'b0);
            settle();
            rd(EPI_OFF_PENDING, (m != 3) ? (32'h40 << p) : 32'h0);
            wr(EPI_OFF_PENDING, 32'hE0);
            pm.set_pin(p, 1'b1);
            settle();
            rd(EPI_OFF_PENDING, (m != 2) ? (32'h40 << p) : 32'h0);
         end
      end
      // Short pulse on a, only a enabled
      wr(EPI_OFF_SENSE, 32'h0F);
      wr(EPI_OFF_ENABLE, 32'h40);
      wr(EPI_OFF_PENDING, 32'hE0);
      pm.set_pin(0, 1'b0);
      pm.set_pin(0, 1'b1);
      settle();
      chk({29'h0, irq_req_c, irq_req_b, irq_req_a}, 32'h1);
      cpu_global_ie <= 1'b0;
      repeat (3) @(posedge clk);
      chk({31'h0, irq_req_a}, 32'h0);
      cpu_global_ie <= 1'b1;
      pm.auto_ack = 1'b1;
      settle();
      rd(EPI_OFF_PENDING, 32'h0);
      pm.auto_ack = 1'b0;
      // Halted I/O clock hides b edges
      wr(EPI_OFF_ENABLE, 32'hE0);
      io_clk_run <= 1'b0;
      pm.set_pin(1, 1'b0);
      pm.set_pin(1, 1'b1);
      settle();
      rd(EPI_OFF_PENDING, 32'h0);
      io_clk_run <= 1'b1;
      // Pin a as output, toggled by the port
      port_dir <= 3'h1;
      settle();
      port_out <= 3'h1;
      settle();
      rd(EPI_OFF_PENDING, 32'h40);
      port_dir <= 3'h0;
      wr(EPI_OFF_PENDING, 32'hE0);
      // Pin c edge choice, changed the safe way
      for (int e = 0; e < 2; e++) begin
         wr(EPI_OFF_ENABLE, 32'hC0);
         wr(EPI_OFF_CRS, e << 6);
         wr(EPI_OFF_PENDING, 32'hE0);
         wr(EPI_OFF_ENABLE, 32'hE0);
         pm.set_pin(2, 1'b0);
         settle();
         rd(EPI_OFF_PENDING, e ? 32'h0 : 32'h20);
         chk({31'h0, irq_req_c}, e ? 32'h0 : 32'h1);
         wr(EPI_OFF_PENDING, 32'hE0);
         settle();
         rd(EPI_OFF_PENDING, 32'h0);
         pm.set_pin(2, 1'b1);
         settle();
         rd(EPI_OFF_PENDING, e ? 32'h20 : 32'h0);
         wr(EPI_OFF_PENDING, 32'hE0);
      end
      // Low level on a, held by the driver
      wr(EPI_OFF_SENSE, 32'h00);
      pm.set_pin(0, 1'b0);
      settle();
      chk({31'h0, irq_req_a}, 32'h1);
      rd(EPI_OFF_PENDING, 32'h0);
      pm.set_pin(0, 1'b1);
      settle();
      chk({31'h0, irq_req_a}, 32'h0);
      // Event status, mask and the event interrupt
      wr(EPI_OFF_SENSE, 32'h03);
      wr(EPI_OFF_STATUS, 32'hF);
      wr(EPI_OFF_MASK, 32'h0);
      pm.set_pin(0, 1'b0);
      pm.set_pin(0, 1'b1);
      settle();
      chk({31'h0, irq}, 32'h0);
      rd(EPI_OFF_STATUS, 32'h1);
      wr(EPI_OFF_MASK, 32'h1);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(EPI_OFF_STATUS, 32'h1);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      // Level wake from deep sleep, level gone before start-up
      wr(EPI_OFF_SENSE, 32'h00);
      wr(EPI_OFF_ENABLE, 32'h40);
      sleep_deep <= 1'b1;
      io_clk_run <= 1'b0;
      pm.set_pin(0, 1'b0);
      repeat (4) @(posedge clk);
      tick();
      repeat (3) @(posedge clk);
      chk({31'h0, wake_req}, 32'h0);
      tick();
      repeat (3) @(posedge clk);
      chk({31'h0, wake_req}, 32'h1);
      pm.set_pin(0, 1'b1);
      sleep_deep <= 1'b0;
      io_clk_run <= 1'b1;
      repeat (4) @(posedge clk);
      startup_done <= 1'b1;
      @(posedge clk);
      startup_done <= 1'b0;
      settle();
      chk({30'h0, wake_req, irq_req_a}, 32'h0);
      rd(EPI_OFF_STATUS, 32'h8);
      close_out();
   end
endmodule : testbench
